// ---- rtl/bts_core.sv ----
`timescale 1ns/1ps
module bts_core (
    input  wire logic                   clock_i,
    input  wire logic                   arst_n_i,
    input  wire logic                   instr_valid_i,
    input  wire logic [15:0]            instr_i,
    input  wire logic                   next_two_word_i,
    input  wire logic                   ext_set_en_i,
    input  wire logic [3:0]             bank_select_reg_i,
    input  wire logic [11:0]            index_base_i,
    input  wire logic [7:0]             rd_data_i,
    output logic                        busy_o,
    output logic [11:0]                 mem_addr_o,
    output logic                        mem_rd_o,
    output logic                        mem_wr_o,
    output logic [7:0]                  wr_data_o,
    output logic                        discard_o,
    output logic                        skip_o
);
    import bts_pkg::*;

    function automatic logic [11:0] resolve_addr(input logic acc, input logic [7:0] f,
                                                 input logic ext, input logic [3:0] bank,
                                                 input logic [11:0] base);
        logic [11:0] a;
        a = 12'h000;
        if (acc) begin
            a = {bank, f};
        end else if (ext && f <= INDEXED_MAX) begin
            a = 12'(base + {4'h0, f});
        end else if (f < ACCESS_SPLIT) begin
            a = {ACCESS_LOW_BANK, f};
        end else begin
            a = {ACCESS_HIGH_BANK, f};
        end
        return a;
    endfunction : resolve_addr

    bts_state_e  state_r, state_nxt;
    logic [15:0] op_r, op_nxt;
    logic        two_r, two_nxt;
    logic [11:0] addr_r, addr_nxt;
    logic        wr_r, wr_nxt;
    logic [7:0]  wd_r, wd_nxt;
    logic        skip_r, skip_nxt;
    logic        disc_r, disc_nxt;
    logic [2:0]  bsel;
    logic        tbit;
    logic [3:0]  opc;

    assign opc  = op_r[OPC_MSB -: 4];
    assign bsel = op_r[BIT_MSB:BIT_LSB];
    assign tbit = rd_data_i[bsel];

    always_comb begin
        state_nxt = state_r;
        op_nxt    = op_r;
        two_nxt   = two_r;
        addr_nxt  = addr_r;
        wr_nxt    = 1'b0;
        wd_nxt    = wd_r;
        skip_nxt  = 1'b0;
        disc_nxt  = 1'b0;
        case (state_r)
            BTS_IDLE: begin
                if (instr_valid_i && (instr_i[OPC_MSB -: 4] == OP_SET_BIT
                    || instr_i[OPC_MSB -: 4] == OP_TEST_SKIP_CLR
                    || instr_i[OPC_MSB -: 4] == OP_TEST_SKIP_SET)) begin
                    op_nxt    = instr_i;
                    addr_nxt  = resolve_addr(instr_i[ACC_POS], instr_i[FADR_MSB:0],
                                             ext_set_en_i, bank_select_reg_i, index_base_i);
                    state_nxt = BTS_EXEC;
                end
            end
            BTS_EXEC: begin
                two_nxt   = next_two_word_i;
                state_nxt = BTS_IDLE;
                if (opc == OP_SET_BIT) begin
                    wr_nxt = 1'b1;
                    wd_nxt = rd_data_i | (8'h01 << bsel);
                end else if ((opc == OP_TEST_SKIP_CLR && !tbit)
                          || (opc == OP_TEST_SKIP_SET && tbit)) begin
                    skip_nxt  = 1'b1;
                    disc_nxt  = 1'b1;
                    state_nxt = BTS_SKIP1;
                end
            end
            BTS_SKIP1: begin
                disc_nxt  = two_r;
                state_nxt = two_r ? BTS_SKIP2 : BTS_IDLE;
            end
            BTS_SKIP2: begin
                state_nxt = BTS_IDLE;
            end
            default: state_nxt = BTS_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= BTS_IDLE;
            op_r    <= 16'h0000;
            two_r   <= 1'b0;
            addr_r  <= ADDR_RESET;
            wr_r    <= 1'b0;
            wd_r    <= 8'h00;
            skip_r  <= 1'b0;
            disc_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            op_r    <= op_nxt;
            two_r   <= two_nxt;
            addr_r  <= addr_nxt;
            wr_r    <= wr_nxt;
            wd_r    <= wd_nxt;
            skip_r  <= skip_nxt;
            disc_r  <= disc_nxt;
        end
    end

    assign busy_o     = (state_r != BTS_IDLE);
    assign mem_addr_o = addr_r;
    assign mem_rd_o   = (state_r == BTS_EXEC);
    assign mem_wr_o   = wr_r;
    assign wr_data_o  = wd_r;
    assign discard_o  = disc_r;
    assign skip_o     = skip_r;

    // decode and bit set checks
    chk_decode: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (state_r == BTS_IDLE && instr_valid_i && instr_i[OPC_MSB -: 4] == OP_SET_BIT)
        |=> state_r == BTS_EXEC ##1 mem_wr_o)
        else $error("bit set not decoded");
    chk_other_ignored: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (state_r == BTS_IDLE && !(instr_valid_i && (instr_i[OPC_MSB -: 4] == OP_SET_BIT
                                   || instr_i[OPC_MSB -: 4] == OP_TEST_SKIP_CLR
                                   || instr_i[OPC_MSB -: 4] == OP_TEST_SKIP_SET)))
        |=> !busy_o && $stable(mem_addr_o))
        else $error("foreign opcode taken");
    chk_set_writes_bit: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (state_r == BTS_EXEC && opc == OP_SET_BIT) |=> mem_wr_o && wr_data_o[$past(bsel)]
        && ((wr_data_o & ~(8'h01 << $past(bsel)))
            == ($past(rd_data_i) & ~(8'h01 << $past(bsel)))))
        else $error("set bit write wrong");
    chk_read_in_exec: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (state_r == BTS_IDLE && state_nxt == BTS_EXEC) |=> mem_rd_o && busy_o && !mem_wr_o)
        else $error("read cycle missing");
    chk_rd_one_cycle: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        mem_rd_o |=> !mem_rd_o)
        else $error("read longer than one cycle");
    chk_set_no_skip: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (state_r == BTS_EXEC && opc == OP_SET_BIT) |=> !skip_o && !discard_o && !busy_o)
        else $error("bit set took a skip");
    chk_write_pulse: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        mem_wr_o |=> !mem_wr_o)
        else $error("write longer than one cycle");
    chk_write_addr: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        mem_wr_o |-> mem_addr_o == $past(mem_addr_o))
        else $error("write address moved");

    // address resolution checks
    chk_access_bank: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (state_r == BTS_IDLE && state_nxt == BTS_EXEC && !instr_i[ACC_POS]
         && (!ext_set_en_i || instr_i[FADR_MSB:0] > INDEXED_MAX))
        |=> mem_addr_o[7:0] == $past(instr_i[FADR_MSB:0])
        && mem_addr_o[11:8] == ($past(instr_i[FADR_MSB:0]) < ACCESS_SPLIT
                                ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK))
        else $error("access bank address wrong");
    chk_bank_sel: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (state_r == BTS_IDLE && state_nxt == BTS_EXEC && instr_i[ACC_POS])
        |=> mem_addr_o == {$past(bank_select_reg_i), $past(instr_i[FADR_MSB:0])})
        else $error("bank select address wrong");
    chk_indexed: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (state_r == BTS_IDLE && state_nxt == BTS_EXEC && !instr_i[ACC_POS] && ext_set_en_i
         && instr_i[FADR_MSB:0] <= INDEXED_MAX)
        |=> mem_addr_o == 12'($past(index_base_i) + {4'h0, $past(instr_i[FADR_MSB:0])}))
        else $error("indexed address wrong");

    // bit test and skip checks
    chk_clr_skip: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (state_r == BTS_EXEC && opc == OP_TEST_SKIP_CLR) |=> skip_o == !$past(tbit))
        else $error("skip if clear wrong");
    chk_no_skip_done: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (state_r == BTS_EXEC && ((opc == OP_TEST_SKIP_CLR && tbit)
                              || (opc == OP_TEST_SKIP_SET && !tbit)))
        |=> !skip_o && !discard_o && !busy_o)
        else $error("skip taken without cause");
    chk_set_skip: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (state_r == BTS_EXEC && opc == OP_TEST_SKIP_SET) |=> skip_o == $past(tbit))
        else $error("skip if set wrong");
    chk_test_no_write: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (state_r == BTS_EXEC && opc != OP_SET_BIT) |=> !mem_wr_o)
        else $error("bit test wrote memory");

    // discard sequence and busy hold checks
    chk_skip_pulse: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        skip_o |-> discard_o && busy_o ##1 !skip_o)
        else $error("skip pulse wrong");
    chk_skip_two_word: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (skip_o && two_r) |=> discard_o ##1 !discard_o)
        else $error("two word skip wrong");
    chk_two_word_busy: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (skip_o && two_r) |=> busy_o ##1 !busy_o)
        else $error("two word skip length wrong");
    chk_skip_one_word: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (skip_o && !two_r) |=> !discard_o && !busy_o)
        else $error("one word skip wrong");
    chk_discard_bounded: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        discard_o ##1 discard_o |=> !discard_o)
        else $error("more than two words discarded");
    chk_busy_holds: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        busy_o |=> $stable(op_r) && $stable(mem_addr_o))
        else $error("request taken while busy");

    cov_set: cover property (@(posedge clock_i) disable iff (!arst_n_i) mem_wr_o);
    cov_skip1: cover property (@(posedge clock_i) disable iff (!arst_n_i) skip_o && !two_r);
    cov_skip2: cover property (@(posedge clock_i) disable iff (!arst_n_i) state_r == BTS_SKIP2);
    cov_noskip: cover property (@(posedge clock_i) disable iff (!arst_n_i)
        state_r == BTS_EXEC && opc != OP_SET_BIT ##1 !skip_o);
    cov_indexed: cover property (@(posedge clock_i) disable iff (!arst_n_i)
        state_r == BTS_IDLE && state_nxt == BTS_EXEC && !instr_i[ACC_POS] && ext_set_en_i
        && instr_i[FADR_MSB:0] <= INDEXED_MAX);
endmodule : bts_core

// ---- rtl/bts_pkg.sv ----
package bts_pkg;
    localparam logic [3:0] OP_SET_BIT        = 4'h8;
    localparam logic [3:0] OP_TEST_SKIP_CLR  = 4'hb;
    localparam logic [3:0] OP_TEST_SKIP_SET  = 4'ha;
    localparam int         OPC_MSB           = 15;
    localparam int         BIT_MSB           = 11;
    localparam int         BIT_LSB           = 9;
    localparam int         ACC_POS           = 8;
    localparam int         FADR_MSB          = 7;
    localparam logic [7:0] INDEXED_MAX       = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT      = 8'h60;
    localparam logic [3:0] ACCESS_LOW_BANK   = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK  = 4'hf;
    localparam logic [3:0] BANK_SEL_RESET    = 4'h0;
    localparam logic [11:0] ADDR_RESET       = 12'h000;

    typedef enum logic [1:0] {
        BTS_IDLE  = 2'b00,
        BTS_EXEC  = 2'b01,
        BTS_SKIP1 = 2'b11,
        BTS_SKIP2 = 2'b10
    } bts_state_e;
endpackage : bts_pkg

// ---- tb/bts_mem.sv ----
`timescale 1ns/1ps
// data memory: fixed pattern per address, inverted while not read
module bts_mem (
    input  wire logic [11:0] addr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rd_data_o
);
    logic [7:0] pat;
    assign pat       = addr_i[7:0] ^ {addr_i[11:8], addr_i[11:8]};
    assign rd_data_o = rd_i ? pat : ~pat;
endmodule : bts_mem

// ---- tb/bit_set_and_bit_test_skip_test.sv ----
`timescale 1ns/1ps
module bit_set_and_bit_test_skip_test;
    import bts_pkg::*;
    logic        clock_i = 0, arst_n_i = 0, instr_valid_i = 0, next_two_word_i = 0;
    logic        ext_set_en_i = 0, busy_o, mem_rd_o, mem_wr_o, discard_o, skip_o;
    logic [15:0] instr_i = 0;
    logic [3:0]  bank_select_reg_i = 0, op;
    logic [11:0] index_base_i = 0, mem_addr_o, ad;
    logic [7:0]  rd_data_i, wr_data_o, p, f;
    logic [2:0]  b;
    logic [21:0] e, q[$];
    logic [3:0]  ops[4] = '{OP_SET_BIT, OP_TEST_SKIP_CLR, OP_TEST_SKIP_SET, 4'hc};
    logic        a, chk2 = 0;
    int          fail_count = 0, n_tests = 0, i, j;
    always #5 clock_i = ~clock_i;
    bts_core i_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .next_two_word_i(next_two_word_i), .ext_set_en_i(ext_set_en_i),
        .bank_select_reg_i(bank_select_reg_i), .index_base_i(index_base_i),
        .rd_data_i(rd_data_i), .busy_o(busy_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
        .mem_wr_o(mem_wr_o), .wr_data_o(wr_data_o), .discard_o(discard_o), .skip_o(skip_o));
    bts_mem i_mem (.addr_i(mem_addr_o), .rd_i(mem_rd_o), .rd_data_o(rd_data_i));
    task check(input bit ok, input string m);
        n_tests++;
        if (!ok) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : check
    task conclude;
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    // result watcher
    always @(negedge clock_i) begin
        if (chk2) begin
            check(discard_o === e[20], "second discard");
            chk2 = 0;
        end
        if (mem_wr_o === 1'b1 || skip_o === 1'b1) begin
            if (q.size() == 0) begin
                check(0, "unexpected result");
            end else begin
                e = q.pop_front();
                check(mem_addr_o === e[19:8], "address");
                if (e[21]) begin
                    check(skip_o === 1'b1 && discard_o === 1'b1, "skip");
                    chk2 = 1;
                end else begin
                    check(mem_wr_o === 1'b1 && wr_data_o === e[7:0], "set");
                end
            end
        end
    end
    initial begin
        void'($urandom(32'hef1f8e07));
        repeat (16) @(posedge clock_i);
        check(busy_o === 1'b0 && mem_wr_o === 1'b0 && mem_rd_o === 1'b0
              && skip_o === 1'b0 && discard_o === 1'b0, "reset outputs");
        arst_n_i <= 1;
        for (i = 0; i < 300; i++) begin
            op = ops[$urandom % 4];
            b  = 3'($urandom);
            a  = 1'($urandom);
            f  = 8'($urandom);
            @(posedge clock_i);
            instr_valid_i     <= 1;
            instr_i           <= {op, b, a, f};
            ext_set_en_i      <= 1'($urandom);
            bank_select_reg_i <= 4'($urandom);
            index_base_i      <= 12'($urandom);
            next_two_word_i   <= 1'($urandom);
            #1;
            if (a) ad = {bank_select_reg_i, f};
            else if (ext_set_en_i && f <= INDEXED_MAX) ad = index_base_i + {4'h0, f};
            else ad = {(f < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, f};
            p = ad[7:0] ^ {ad[11:8], ad[11:8]};
            if (op == OP_SET_BIT) q.push_back({1'b0, next_two_word_i, ad, p | (8'h01 << b)});
            if ((op == OP_TEST_SKIP_CLR && !p[b]) || (op == OP_TEST_SKIP_SET && p[b]))
                q.push_back({1'b1, next_two_word_i, ad, 8'h00});
            @(posedge clock_i);
            instr_valid_i <= 0;
            for (j = 0; j < 8; j++) begin
                @(negedge clock_i);
                if (j == 0) check(mem_rd_o === (op != 4'hc), "read strobe");
                if (busy_o !== 1'b1) break;
            end
            if (j == 8) begin
                check(0, "busy timeout");
                break;
            end
        end
        repeat (4) @(posedge clock_i);
        check(q.size() == 0, "missing results");
        $display("test random operations done");
        conclude();
    end
endmodule : bit_set_and_bit_test_skip_test
